/* File: hw/acsr_format.sv */
// Places a 16-bit status response in the top of a device word.
`timescale 1ns/100ps
`default_nettype none
module acsr_format
   import acsr_pkg::*;
(
   input wire logic [15:0] resp,      // Status response.
   input wire acsr_wsize_t wsize,     // Current word size.
   input wire logic ham_en,           // Hamming coding enabled.
   input wire logic [15:0] ham_bits,  // Low bits from the coder.
   output logic [31:0] word           // Left-justified device word.
);
   always_comb begin
      word = {resp, 16'h0000};
      if (ham_en) begin
         case (wsize)
            WS_24: word[15:8] = ham_bits[15:8];
            WS_32: word[15:0] = ham_bits;
            default: word[15:0] = 16'h0000;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: hw/acsr_pkg.sv */
// Shared constants and types of the command status responder.
package acsr_pkg;
   ////////////////////////////////////////////////////////////////////////
   localparam int ACSR_REG_COUNT = 20;
   localparam logic [3:0] ACSR_CHAN_COUNT = 4'h4;
   // Device code nibble; the value is arbitrary.
   localparam logic [3:0] ACSR_DEV_ID = 4'h5;
   localparam logic [15:0] CMD_NULL = 16'h0000;
   localparam logic [15:0] CMD_RESET = 16'h0011;
   localparam logic [15:0] CMD_STANDBY = 16'h0022;
   localparam logic [15:0] CMD_RESUME = 16'h0033;
   localparam logic [15:0] CMD_FREEZE = 16'h0555;
   localparam logic [15:0] CMD_RELEASE = 16'h0655;
   localparam logic [2:0] PFX_SINGLE = 3'h1;
   localparam logic [2:0] PFX_WRITE = 3'h2;
   localparam logic [2:0] PFX_MULTI = 3'h3;
   localparam logic [7:0] READY_HI = 8'hFF;
   localparam logic [4:0] ADDR_ID = 5'h00;
   localparam logic [4:0] ADDR_STAT = 5'h02;
   localparam logic [4:0] ADDR_ASYS = 5'h0B;
   localparam logic [4:0] ADDR_DSYS = 5'h0C;
   localparam logic [4:0] ADDR_CLK1 = 5'h0D;
   localparam logic [4:0] ADDR_CLK2 = 5'h0E;
   localparam logic [4:0] ADDR_CH_ENA = 5'h0F;
   localparam logic [4:0] ADDR_SPARE = 5'h10;
   localparam logic [7:0] RST_ASYS = 8'h60;
   localparam logic [7:0] RST_DSYS = 8'h3C;
   localparam logic [7:0] RST_CLK1 = 8'h08;
   localparam logic [7:0] RST_CLK2 = 8'h86;
   localparam logic [7:0] RST_ZERO = 8'h00;
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      WS_16 = 2'b00,
      WS_24 = 2'b01,
      WS_32 = 2'b10
   } acsr_wsize_t;
   typedef enum logic [1:0] {
      MODE_READY = 2'b00,
      MODE_OPEN = 2'b01,
      MODE_LOCKED = 2'b10
   } acsr_mode_t;
   typedef enum logic [1:0] {
      EX_IDLE = 2'b00,
      EX_WRITE = 2'b01,
      EX_READ = 2'b10,
      EX_LATCH = 2'b11
   } acsr_exec_t;
   typedef struct packed {
      logic [2:0] prefix;
      logic [4:0] addr;
      logic [7:0] arg;
   } acsr_cmd_t;
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] acsr_reset_val(input int a);
      case (a)
         int'(ADDR_ASYS): acsr_reset_val = RST_ASYS;
         int'(ADDR_DSYS): acsr_reset_val = RST_DSYS;
         int'(ADDR_CLK1): acsr_reset_val = RST_CLK1;
         int'(ADDR_CLK2): acsr_reset_val = RST_CLK2;
         default: acsr_reset_val = RST_ZERO;
      endcase
   endfunction
   function automatic logic acsr_writable(input int a);
      acsr_writable = a >= int'(ADDR_ASYS) && a != int'(ADDR_SPARE);
   endfunction
endpackage

/* File: hw/acsr_regs.sv */
// Register space with two registered read ports and one write port.
`timescale 1ns/100ps
`default_nettype none
module acsr_regs
   import acsr_pkg::*;
#(
   parameter int REG_COUNT = ACSR_REG_COUNT
) (
   input wire logic clk,              // System clock.
   input wire logic nrst,             // Synchronous reset, active low.
   input wire logic soft_rst,         // Return all entries to defaults.
   input wire logic we,               // Write strobe.
   input wire logic [4:0] wr_addr,    // Write address.
   input wire logic [7:0] wr_data,    // Write data.
   input wire logic [8:0] rd_addr_a,  // First read address.
   input wire logic [8:0] rd_addr_b,  // Second read address.
   input wire logic [7:0] id_byte,    // Identification byte.
   input wire logic [7:0] stat_byte,  // Live primary status byte.
   output logic [7:0] rd_data_a,      // Registered first read data.
   output logic [7:0] rd_data_b,      // Registered second read data.
   output logic [3:0] ch_ena          // Stored channel enable nibble.
);
   logic [7:0] mem [REG_COUNT];
   logic [7:0] next_rd_data_a;
   logic [7:0] next_rd_data_b;

   ////////////////////////////////////////////////////////////////////////
   genvar i;
   for (i = 0; i < REG_COUNT; i++) begin : g_ent
      logic [7:0] next_val;
      always_comb begin
         next_val = mem[i];
         if (soft_rst) begin
            next_val = acsr_reset_val(i);
         end else if (we && int'(wr_addr) == i && acsr_writable(i)) begin
            next_val = wr_data;
         end
      end
      always_ff @(posedge clk) begin
         if (!nrst) begin
            mem[i] <= acsr_reset_val(i);
         end else begin
            mem[i] <= next_val;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Addresses past the implemented space read as zero.
   function automatic logic [7:0] pick(input logic [8:0] a);
      pick = 8'h00;
      if (int'(a) < REG_COUNT) begin
         if (a[4:0] == ADDR_ID) begin
            pick = id_byte;
         end else if (a[4:0] == ADDR_STAT) begin
            pick = stat_byte;
         end else begin
            pick = mem[a[4:0]];
         end
      end
   endfunction

   always_comb begin
      next_rd_data_a = pick(rd_addr_a);
      next_rd_data_b = pick(rd_addr_b);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_data_a <= 8'h00;
         rd_data_b <= 8'h00;
      end else begin
         rd_data_a <= next_rd_data_a;
         rd_data_b <= next_rd_data_b;
      end
   end

   assign ch_ena = mem[ADDR_CH_ENA][3:0];
endmodule
`default_nettype wire

/* File: hw/acsr_responder.sv */
// Frame-level command decoder and status response generator.
`timescale 1ns/100ps
`default_nettype none
module acsr_responder
   import acsr_pkg::*;
#(
   parameter int REG_COUNT = ACSR_REG_COUNT,
   parameter logic [3:0] CHAN_COUNT = ACSR_CHAN_COUNT
) (
   input wire logic CLK,                // System clock, 40 MHz.
   input wire logic NRST,               // Synchronous reset, active low.
   input wire logic FRAME_END,          // One-cycle pulse, frame done.
   input wire logic [15:0] CMD_WORD,    // Top 16 bits of first word.
   input wire acsr_wsize_t WORD_SIZE,   // Device word size.
   input wire logic HAMMING_EN,         // Hamming coding enabled.
   input wire logic [15:0] HAMMING_BITS,// Coder bits for low lanes.
   input wire logic [7:0] FAULT_STATUS, // Live primary status byte.
   output logic [31:0] RESP_WORD,       // First word of next frame.
   output logic RESP_LOAD,              // Pulse, RESP_WORD updated.
   output logic ONE_WORD_FRAME,         // Ready state, one-word frames.
   output logic LOCKED,                 // Interface frozen.
   output logic STANDBY,                // Conversions halted.
   output logic [3:0] CH_ENABLE         // Applied channel enables.
);
   localparam logic [7:0] ID_BYTE = {ACSR_DEV_ID, CHAN_COUNT};
   localparam logic [15:0] READY_WORD = {READY_HI, 4'h0, CHAN_COUNT};

   acsr_exec_t ex_state;
   acsr_exec_t next_ex_state;
   acsr_cmd_t cmd_q;
   acsr_cmd_t next_cmd_q;
   acsr_mode_t mode;
   acsr_mode_t next_mode;
   logic standby;
   logic next_standby;
   logic mr_active;
   logic next_mr_active;
   logic [8:0] mr_addr;
   logic [8:0] next_mr_addr;
   logic [8:0] mr_left;
   logic [8:0] next_mr_left;
   logic [31:0] next_resp_word;
   logic next_resp_load;
   logic [3:0] next_ch_enable;
   logic [15:0] resp16;
   logic [31:0] fmt_word;
   logic [15:0] cmd16;
   logic is_read;
   logic is_write;
   logic addressed;
   logic we;
   logic soft_rst;
   logic [8:0] rd_addr_a;
   logic [8:0] rd_addr_b;
   logic [7:0] rd_data_a;
   logic [7:0] rd_data_b;
   logic [3:0] ch_ena;

   ////////////////////////////////////////////////////////////////////////
   assign cmd16 = cmd_q;
   assign is_read = cmd_q.prefix == PFX_SINGLE;
   assign is_write = cmd_q.prefix == PFX_WRITE;
   // Writes and reads are held off in ready state and during multi-read.
   assign addressed = !mr_active && mode != MODE_READY &&
                      (is_read || (is_write && mode == MODE_OPEN));
   assign we = ex_state == EX_WRITE && addressed && is_write;
   assign soft_rst = ex_state == EX_WRITE && !mr_active &&
                     mode == MODE_OPEN && cmd16 == CMD_RESET;

   always_comb begin
      if (mr_active) begin
         rd_addr_a = mr_addr;
      end else if (addressed) begin
         rd_addr_a = {4'h0, cmd_q.addr};
      end else begin
         rd_addr_a = {4'h0, ADDR_STAT};
      end
      rd_addr_b = 9'(rd_addr_a + 9'h001);
   end

   acsr_regs #(
      .REG_COUNT(REG_COUNT)
   ) u_regs (
      .clk(CLK),
      .nrst(NRST),
      .soft_rst(soft_rst),
      .we(we),
      .wr_addr(cmd_q.addr),
      .wr_data(cmd_q.arg),
      .rd_addr_a(rd_addr_a),
      .rd_addr_b(rd_addr_b),
      .id_byte(ID_BYTE),
      .stat_byte(FAULT_STATUS),
      .rd_data_a(rd_data_a),
      .rd_data_b(rd_data_b),
      .ch_ena(ch_ena)
   );

   acsr_format u_format (
      .resp(resp16),
      .wsize(WORD_SIZE),
      .ham_en(HAMMING_EN),
      .ham_bits(HAMMING_BITS),
      .word(fmt_word)
   );

   ////////////////////////////////////////////////////////////////////////
   // Execution runs write, read and latch over three cycles after the
   // frame end; the response is ready long before the next frame's
   // first serial bit, so the shifter never sees a half-built word.
   always_comb begin
      next_ex_state = ex_state;
      next_cmd_q = cmd_q;
      case (ex_state)
         EX_IDLE: begin
            if (FRAME_END) begin
               next_cmd_q = CMD_WORD;
               next_ex_state = EX_WRITE;
            end
         end
         EX_WRITE: next_ex_state = EX_READ;
         EX_READ: next_ex_state = EX_LATCH;
         EX_LATCH: next_ex_state = EX_IDLE;
         default: next_ex_state = EX_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         ex_state <= EX_IDLE;
         cmd_q <= '0;
      end else begin
         ex_state <= next_ex_state;
         cmd_q <= next_cmd_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Response decode; outside ready state and multi-read output, unrecognised commands fall back to status readback.
   always_comb begin
      next_mode = mode;
      next_standby = standby;
      next_mr_active = mr_active;
      next_mr_addr = mr_addr;
      next_mr_left = mr_left;
      resp16 = {PFX_SINGLE, ADDR_STAT, rd_data_a};
      if (mr_active) begin
         resp16 = {rd_data_a, (mr_left > 9'h001) ? rd_data_b : 8'h00};
         next_mr_addr = 9'(mr_addr + 9'h002);
         next_mr_left = (mr_left > 9'h002) ? 9'(mr_left - 9'h002) : 9'h000;
         next_mr_active = mr_left > 9'h002;
      end else if (mode == MODE_READY) begin
         resp16 = READY_WORD;
         if (cmd16 == CMD_RELEASE) begin
            resp16 = CMD_RELEASE;
            next_mode = MODE_OPEN;
         end
      end else if (is_read) begin
         resp16 = {PFX_SINGLE, cmd_q.addr, rd_data_a};
         if (cmd_q.arg != 8'h00) begin
            resp16 = cmd16 | {PFX_MULTI, 13'h0000};
            next_mr_active = 1'b1;
            next_mr_addr = {4'h0, cmd_q.addr};
            next_mr_left = 9'({1'b0, cmd_q.arg} + 9'h001);
         end
      end else if (cmd16 == CMD_RELEASE) begin
         resp16 = CMD_RELEASE;
         next_mode = MODE_OPEN;
      end else if (mode == MODE_OPEN) begin
         if (is_write) begin
            resp16 = {PFX_SINGLE, cmd_q.addr, rd_data_a};
         end else if (cmd16 == CMD_RESET) begin
            resp16 = READY_WORD;
            next_mode = MODE_READY;
            next_standby = 1'b0;
         end else if (cmd16 == CMD_STANDBY) begin
            resp16 = CMD_STANDBY;
            next_standby = 1'b1;
         end else if (cmd16 == CMD_RESUME) begin
            resp16 = CMD_RESUME;
            next_standby = 1'b0;
         end else if (cmd16 == CMD_FREEZE) begin
            resp16 = CMD_FREEZE;
            next_mode = MODE_LOCKED;
         end
      end
      if (ex_state != EX_LATCH) begin
         next_mode = mode;
         next_standby = standby;
         next_mr_active = mr_active;
         next_mr_addr = mr_addr;
         next_mr_left = mr_left;
      end
      next_resp_load = ex_state == EX_LATCH;
      next_resp_word = next_resp_load ? fmt_word : RESP_WORD;
      // Enables written in standby wait until resume to take effect.
      next_ch_enable = next_standby ? CH_ENABLE : ch_ena;
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         mode <= MODE_READY;
         standby <= 1'b0;
         mr_active <= 1'b0;
         mr_addr <= 9'h000;
         mr_left <= 9'h000;
         RESP_WORD <= {READY_WORD, 16'h0000};
         RESP_LOAD <= 1'b0;
         ONE_WORD_FRAME <= 1'b1;
         LOCKED <= 1'b0;
         STANDBY <= 1'b0;
         CH_ENABLE <= 4'h0;
      end else begin
         mode <= next_mode;
         standby <= next_standby;
         mr_active <= next_mr_active;
         mr_addr <= next_mr_addr;
         mr_left <= next_mr_left;
         RESP_WORD <= next_resp_word;
         RESP_LOAD <= next_resp_load;
         ONE_WORD_FRAME <= next_mode == MODE_READY;
         LOCKED <= next_mode == MODE_LOCKED;
         STANDBY <= next_standby;
         CH_ENABLE <= next_ch_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic latch_cmd;
   assign latch_cmd = ex_state == EX_LATCH && !mr_active;

   property p_latch_delay;
      @(posedge CLK) disable iff (!NRST)
      FRAME_END && ex_state == EX_IDLE |=> !RESP_LOAD [*3] ##1 RESP_LOAD;
   endproperty
   a_latch_delay: assert property (p_latch_delay)
      else $error("response not latched three cycles after frame end");

   property p_ready_word;
      @(posedge CLK) disable iff (!NRST)
      RESP_LOAD && ONE_WORD_FRAME |-> RESP_WORD[31:16] == READY_WORD;
   endproperty
   a_ready_word: assert property (p_ready_word)
      else $error("ready state sent a word other than ready");

   property p_ready_ignore;
      @(posedge CLK) disable iff (!NRST)
      latch_cmd && mode == MODE_READY && cmd16 != CMD_RELEASE
      |=> mode == MODE_READY && $stable(STANDBY);
   endproperty
   a_ready_ignore: assert property (p_ready_ignore)
      else $error("ready state acted on a command other than release");

   property p_release;
      @(posedge CLK) disable iff (!NRST)
      latch_cmd && mode != MODE_OPEN && cmd16 == CMD_RELEASE
      |=> RESP_WORD[31:16] == 16'h0655 && !LOCKED && !ONE_WORD_FRAME;
   endproperty
   a_release: assert property (p_release)
      else $error("release did not open the interface with 0655h");

   property p_null_status;
      @(posedge CLK) disable iff (!NRST)
      latch_cmd && mode != MODE_READY && cmd16 == CMD_NULL
      |=> RESP_WORD[31:16] == {PFX_SINGLE, ADDR_STAT, $past(FAULT_STATUS, 2)}
          && $stable(CH_ENABLE) && mode == $past(mode);
   endproperty
   a_null_status: assert property (p_null_status)
      else $error("null command did not return status readback");

   property p_standby;
      @(posedge CLK) disable iff (!NRST)
      latch_cmd && mode == MODE_OPEN && cmd16 == CMD_STANDBY
      |=> STANDBY && RESP_WORD[31:16] == 16'h0022;
   endproperty
   a_standby: assert property (p_standby)
      else $error("standby not entered with 0022h");

   property p_resume;
      @(posedge CLK) disable iff (!NRST)
      latch_cmd && mode == MODE_OPEN && cmd16 == CMD_RESUME
      |=> !STANDBY && RESP_WORD[31:16] == 16'h0033 ##1 CH_ENABLE == ch_ena;
   endproperty
   a_resume: assert property (p_resume)
      else $error("resume did not leave standby with 0033h");

   property p_freeze;
      @(posedge CLK) disable iff (!NRST)
      latch_cmd && mode == MODE_OPEN && cmd16 == CMD_FREEZE
      |=> LOCKED && RESP_WORD[31:16] == 16'h0555;
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("freeze did not lock with 0555h");

   property p_multi_ignore;
      @(posedge CLK) disable iff (!NRST)
      ex_state == EX_LATCH && mr_active
      |=> mode == $past(mode) && STANDBY == $past(standby);
   endproperty
   a_multi_ignore: assert property (p_multi_ignore)
      else $error("command acted on during multi-read output");

   property p_zero_lsb;
      @(posedge CLK) disable iff (!NRST)
      RESP_LOAD && !$past(HAMMING_EN) |-> RESP_WORD[15:0] == 16'h0000;
   endproperty
   a_zero_lsb: assert property (p_zero_lsb)
      else $error("unused response bits not zero");

   property p_soft_reset;
      @(posedge CLK) disable iff (!NRST)
      soft_rst |-> ##3 RESP_LOAD && ONE_WORD_FRAME && !STANDBY;
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("software reset did not return to ready");

   property p_no_write_locked;
      @(posedge CLK) disable iff (!NRST)
      mode != MODE_OPEN || mr_active |-> !we;
   endproperty
   a_no_write_locked: assert property (p_no_write_locked)
      else $error("register written outside the open state");
endmodule
`default_nettype wire

/* File: verif/acsr_host.sv */
// Host model that sends one command word per frame to the responder.
`timescale 1ns/100ps
`default_nettype none
module acsr_host (
   input wire logic clk,          // System clock.
   output logic frame_end,        // Frame complete pulse.
   output logic [15:0] cmd_word   // Command in the first device word.
);
   initial begin
      frame_end = 1'b0;
      cmd_word = 16'hFFFF;
   end
   // After the frame the line shows the inverse, so a stale word never
   // passes for a fresh one.
   task automatic send(input logic [15:0] c);
      @(negedge clk);
      frame_end = 1'b1;
      cmd_word = c;
      @(negedge clk);
      frame_end = 1'b0;
      cmd_word = ~c;
   endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking testbench of the command status responder.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import acsr_pkg::*;
   logic clk, nrst, frame_end, ham_en, resp_load, owf, lk, sb;
   logic [15:0] cmd_word, ham_bits, st, rdy;
   logic [7:0] fault;
   logic [31:0] resp_word;
   logic [3:0] ch_en;
   acsr_wsize_t ws;
   int fails, n_checks;
   assign st = {PFX_SINGLE, ADDR_STAT, fault};
   assign rdy = {READY_HI, 4'h0, ACSR_CHAN_COUNT};
   ////////////////////////////////////////////////////////////////////////
   acsr_host i_host (.clk(clk), .frame_end(frame_end), .cmd_word(cmd_word));
   acsr_responder i_dut (.CLK(clk), .NRST(nrst), .FRAME_END(frame_end),
      .CMD_WORD(cmd_word), .WORD_SIZE(ws), .HAMMING_EN(ham_en),
      .HAMMING_BITS(ham_bits), .FAULT_STATUS(fault), .RESP_WORD(resp_word),
      .RESP_LOAD(resp_load), .ONE_WORD_FRAME(owf), .LOCKED(lk),
      .STANDBY(sb), .CH_ENABLE(ch_en));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Sends one frame and compares the status response that answers it.
   task automatic cmd(input logic [15:0] c, input logic [15:0] exp);
      int n;
      i_host.send(c);
      n = 0;
      while (resp_load !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(32'(resp_load), 32'h0000_0001);
      chk(32'(resp_word[31:16]), 32'(exp));
      @(posedge clk);
      #1;
   endtask
   task automatic mode(input logic [2:0] exp);
      chk(32'({owf, lk, sb}), 32'(exp));
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_ready;
      chk(resp_word, {rdy, 16'h0000});
      mode(3'h4);
      cmd(CMD_STANDBY, rdy);
      mode(3'h4);
      cmd(CMD_RELEASE, CMD_RELEASE);
      mode(3'h0);
      $display("test ready done");
   endtask
   task automatic t_null_write;
      cmd(CMD_NULL, st);
      chk(32'(ch_en), 32'h0000_0000);
      @(negedge clk);
      ws = WS_24;
      cmd(16'h4F05, 16'h2F05);
      chk(32'(resp_word[15:0]), 32'h0000_0000);
      chk(32'(ch_en), 32'h0000_0005);
      @(negedge clk);
      ws = WS_32;
      ham_en = 1'b1;
      cmd(CMD_NULL, st);
      chk(32'(resp_word[15:0]), 32'h0000_BEEF);
      @(negedge clk);
      ws = WS_16;
      ham_en = 1'b0;
      $display("test null and write done");
   endtask
   task automatic t_standby;
      cmd(16'h4F00, 16'h2F00);
      cmd(CMD_STANDBY, CMD_STANDBY);
      mode(3'h1);
      cmd(16'h4F03, 16'h2F03);
      chk(32'(ch_en), 32'h0000_0000);
      cmd(CMD_RESUME, CMD_RESUME);
      mode(3'h0);
      chk(32'(ch_en), 32'h0000_0003);
      cmd(CMD_NULL, st);
      chk(32'(ch_en), 32'h0000_0003);
      mode(3'h0);
      $display("test standby done");
   endtask
   task automatic t_multi;
      cmd(16'h537E, 16'h337E);
      cmd(16'h3302, 16'h7302);
      cmd(CMD_RESET, 16'h7E00);
      cmd(CMD_NULL, 16'h0000);
      cmd(CMD_RESET, rdy);
      mode(3'h4);
      chk(32'(ch_en), 32'h0000_0000);
      cmd(CMD_RELEASE, CMD_RELEASE);
      cmd(16'h2B00, 16'h2B60);
      cmd(16'h3300, 16'h3300);
      $display("test multi read and reset done");
   endtask
   task automatic t_freeze;
      cmd(CMD_FREEZE, CMD_FREEZE);
      mode(3'h2);
      cmd(CMD_NULL, st);
      cmd(16'h4F0F, st);
      chk(32'(ch_en), 32'h0000_0000);
      cmd(CMD_STANDBY, st);
      mode(3'h2);
      cmd(16'h2B00, 16'h2B60);
      cmd(CMD_RELEASE, CMD_RELEASE);
      mode(3'h0);
      $display("test freeze done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // A frame takes about five cycles; the whole run needs well under 600.
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      report_and_stop();
   end
   initial begin
      fails = 0;
      n_checks = 0;
      nrst = 1'b0;
      ws = WS_16;
      ham_en = 1'b0;
      ham_bits = 16'hBEEF;
      fault = 8'hA5;
      repeat (8) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      #1;
      t_ready();
      t_null_write();
      t_standby();
      t_multi();
      t_freeze();
      report_and_stop();
   end
endmodule
`default_nettype wire
